// ==== design/plos_sequencer.sv ====
// pfc and llc operation sequencer, top level
// ------------------------------------------------------------
// ------------------------------------------------------------
module plos_sequencer
  import plos_pkg::*;
#(
  parameter int unsigned ON_W = 16,
  parameter int unsigned PER_W = 16,
  parameter int unsigned CNT_W = 26,
  parameter int unsigned BO_CYC = BO_BLANK_CYC,
  parameter int unsigned AR_CYC = AR_BREAK_CYC,
  parameter int unsigned OLP_CYC = OLP_TIME_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic bus_open_loop_i,
  input wire logic bus_near_rated_i,
  input wire logic bus_undervoltage_i,
  input wire logic bridge_startup_bus_i,
  input wire logic bus_overvoltage_firmware_i,
  input wire logic bus_overvoltage_hardware_i,
  input wire logic bus_below_reference_i,
  input wire logic correction_overcurrent_i,
  input wire logic zero_crossing_i,
  input wire logic [ON_W-1:0] on_time_request_i,
  input wire logic line_brownout_i,
  input wire logic long_ccm_i,
  input wire logic bridge_overcurrent_level1_i,
  input wire logic bridge_overcurrent_level2_i,
  input wire logic bridge_feedback_high_i,
  input wire logic [PER_W-1:0] bridge_feedback_period_i,
  input wire logic level2_status_clear_i,
  output logic setup_load_o,
  output logic correction_gate_o,
  output logic bridge_gate_high_o,
  output logic bridge_gate_low_o,
  output logic correction_sense_en_o,
  output logic bridge_sense_en_o,
  output logic integrator_limit_o,
  output logic [PER_W-1:0] bridge_period_o,
  output logic level2_status_o,
  output logic auto_restart_o,
  output logic [1:0] correction_state_o,
  output logic [1:0] bridge_state_o
);

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (PER_W < 16 || CNT_W > 31 ||
      AR_CYC >= (32'h0000_0001 << CNT_W) ||
      BO_CYC >= (32'h0000_0001 << CNT_W) ||
      OLP_CYC >= (32'h0000_0001 << CNT_W) ||
      AR_CYC < 1 || BO_CYC < 1 || OLP_CYC < 1) begin : g_chk
    $error("plos_sequencer: parameters out of range");
  end

  localparam logic [CNT_W-1:0] AR_LIM = CNT_W'(AR_CYC);
  localparam logic [CNT_W-1:0] BO_LIM = CNT_W'(BO_CYC);
  localparam logic [CNT_W-1:0] OLP_LIM = CNT_W'(OLP_CYC);
  localparam logic [CNT_W-1:0] INIT_LIM = CNT_W'(INIT_CYC);
  localparam logic [PER_W-1:0] P_ONE = {{(PER_W-1){1'b0}}, 1'b1};
  localparam logic [PER_W-1:0] P_START = PER_W'(TCO_START_PER);
  localparam logic [PER_W-1:0] P_END = PER_W'(TCO_END_PER);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  plos_sys_t sys_r;
  plos_sys_t sys_nxt;
  plos_cor_t cor_r;
  plos_cor_t cor_nxt;
  plos_brg_t brg_r;
  plos_brg_t brg_nxt;

  logic ovp_block_r;
  logic lvl2_stat_r;
  logic restart_r;
  logic [PER_W-1:0] tco_per_r;
  logic [15:0] tco_tick_r;
  logic [PER_W-1:0] bcnt_r;
  logic [PER_W-1:0] bper_r;
  logic gh_r;
  logic gl_r;
  logic bridge_overcurrent_level1_seen_r;
  logic [3:0] bridge_overcurrent_level1_cnt_r;

  logic init_done;
  logic break_done;
  logic bo_done;
  logic olp_done;

  // ------------------------------------------------------------
  // timers
  // ------------------------------------------------------------
  plos_timer #(.W(CNT_W)) u_init_tmr (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(sys_r == SYS_INIT),
    .limit_i(INIT_LIM),
    .done_o(init_done)
  );

  plos_timer #(.W(CNT_W)) u_break_tmr (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(sys_r == SYS_BREAK),
    .limit_i(AR_LIM),
    .done_o(break_done)
  );

  plos_timer #(.W(CNT_W)) u_bo_tmr (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(line_brownout_i),
    .limit_i(BO_LIM),
    .done_o(bo_done)
  );

  plos_timer #(.W(CNT_W)) u_olp_tmr (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .run_i(bridge_feedback_high_i && brg_r == BRG_NORM),
    .limit_i(OLP_LIM),
    .done_o(olp_done)
  );

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire run = (sys_r == SYS_RUN);
  wire cor_en = run && !bo_done;
  wire cor_act = (cor_r == COR_SOFT) || (cor_r == COR_NORM);
  wire brg_act = (brg_r == BRG_SOFT) || (brg_r == BRG_NORM);
  wire ovp_any = bus_overvoltage_firmware_i ||
                 bus_overvoltage_hardware_i;
  wire tco_meet = (bridge_feedback_period_i <= tco_per_r);
  wire [PER_W-1:0] per_sel = (brg_r == BRG_NORM) ?
                             bridge_feedback_period_i : tco_per_r;
  wire [PER_W-1:0] half = bper_r >> 1;
  wire cyc_end = brg_act && (bcnt_r + P_ONE >= bper_r);
  wire bridge_overcurrent_level1_hit = bridge_overcurrent_level1_seen_r || bridge_overcurrent_level1_i;
  wire bridge_overcurrent_level1_trip = cyc_end && bridge_overcurrent_level1_hit &&
                   (bridge_overcurrent_level1_cnt_r == BRIDGE_OVERCURRENT_LEVEL1_LIMIT);
  wire ccm_trip = long_ccm_i && cor_act;
  wire ar_req = bridge_overcurrent_level2_i ||
                bridge_overcurrent_level1_trip || olp_done || ccm_trip;
  wire tco_step = (tco_tick_r >= TCO_STEP_CYC - 16'h0001);
  wire [PER_W-1:0] tco_nxt = (tco_step && tco_per_r < P_END) ?
                             tco_per_r + P_ONE : tco_per_r;
  wire [PER_W-1:0] bcnt_nxt = cyc_end ? '0 : bcnt_r + P_ONE;
  wire [3:0] bridge_overcurrent_level1_nxt = bridge_overcurrent_level1_hit ? bridge_overcurrent_level1_cnt_r + 4'h1 : 4'h0;

  // ------------------------------------------------------------
  // system sequence
  // ------------------------------------------------------------
  always_comb begin
    sys_nxt = sys_r;
    unique case (sys_r)
      SYS_INIT: begin
        if (init_done) begin
          sys_nxt = SYS_RUN;
        end
      end
      SYS_RUN: begin
        if (ar_req) begin
          sys_nxt = SYS_BREAK;
        end
      end
      SYS_BREAK: begin
        if (break_done) begin
          sys_nxt = SYS_RUN;
        end
      end
      default: sys_nxt = SYS_INIT;
    endcase
  end

  // ------------------------------------------------------------
  // correction stage sequence
  // ------------------------------------------------------------
  always_comb begin
    cor_nxt = cor_r;
    unique case (cor_r)
      COR_OFF: begin
        if (cor_en) begin
          cor_nxt = COR_LOOPCHK;
        end
      end
      COR_LOOPCHK: begin
        if (!bus_open_loop_i) begin
          cor_nxt = COR_SOFT;
        end
      end
      COR_SOFT: begin
        if (bus_near_rated_i) begin
          cor_nxt = COR_NORM;
        end
      end
      COR_NORM: cor_nxt = COR_NORM;
    endcase
    if (!cor_en || ar_req) begin
      cor_nxt = COR_OFF;
    end
  end

  // ------------------------------------------------------------
  // bridge sequence
  // ------------------------------------------------------------
  always_comb begin
    brg_nxt = brg_r;
    unique case (brg_r)
      BRG_OFF: begin
        if (run) begin
          brg_nxt = restart_r ? BRG_SOFT : BRG_BUSCHK;
        end
      end
      BRG_BUSCHK: begin
        if (bridge_startup_bus_i) begin
          brg_nxt = BRG_SOFT;
        end
      end
      BRG_SOFT: begin
        if (bus_undervoltage_i) begin
          brg_nxt = BRG_BUSCHK;
        end else if (tco_meet) begin
          brg_nxt = BRG_NORM;
        end
      end
      BRG_NORM: begin
        if (bus_undervoltage_i) begin
          brg_nxt = BRG_BUSCHK;
        end
      end
    endcase
    if (!run || ar_req) begin
      brg_nxt = BRG_OFF;
    end
  end

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      sys_r <= SYS_INIT;
      cor_r <= COR_OFF;
      brg_r <= BRG_OFF;
    end else begin
      sys_r <= sys_nxt;
      cor_r <= cor_nxt;
      brg_r <= brg_nxt;
    end
  end

  // after a break the bridge skips the bus check
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      restart_r <= 1'b0;
    end else if (sys_r == SYS_BREAK) begin
      restart_r <= 1'b1;
    end else if (brg_r != BRG_OFF) begin
      restart_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // overvoltage gate block, set wins over release
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ovp_block_r <= 1'b0;
    end else if (ovp_any) begin
      ovp_block_r <= 1'b1;
    end else if (bus_below_reference_i) begin
      ovp_block_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // level-2 comparator status, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lvl2_stat_r <= 1'b0;
    end else if (bridge_overcurrent_level2_i) begin
      lvl2_stat_r <= 1'b1;
    end else if (level2_status_clear_i) begin
      lvl2_stat_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // softstart oscillator, period grows with time
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || brg_r != BRG_SOFT) begin
      tco_per_r <= P_START;
      tco_tick_r <= 16'h0000;
    end else begin
      tco_per_r <= tco_nxt;
      tco_tick_r <= tco_step ? 16'h0000 : tco_tick_r + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // bridge switching cycle and gates
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !brg_act) begin
      bcnt_r <= '0;
      bper_r <= P_START;
      gh_r <= 1'b0;
      gl_r <= 1'b0;
    end else begin
      bcnt_r <= bcnt_nxt;
      bper_r <= cyc_end ? per_sel : bper_r;
      gh_r <= (bcnt_r < half);
      gl_r <= (bcnt_r >= half);
    end
  end

  // ------------------------------------------------------------
  // consecutive level-1 overcurrent count
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !brg_act) begin
      bridge_overcurrent_level1_seen_r <= 1'b0;
      bridge_overcurrent_level1_cnt_r <= 4'h0;
    end else if (cyc_end) begin
      bridge_overcurrent_level1_seen_r <= 1'b0;
      bridge_overcurrent_level1_cnt_r <= bridge_overcurrent_level1_nxt;
    end else if (bridge_overcurrent_level1_i) begin
      bridge_overcurrent_level1_seen_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // correction gate
  // ------------------------------------------------------------
  plos_corr_gate #(.W(ON_W)) u_corr_gate (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(cor_act),
    .zero_cross_i(zero_crossing_i),
    .overcurrent_i(correction_overcurrent_i),
    .block_i(ovp_block_r),
    .on_req_i(on_time_request_i),
    .gate_o(correction_gate_o)
  );

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign setup_load_o = (sys_r == SYS_INIT);
  assign bridge_gate_high_o = gh_r;
  assign bridge_gate_low_o = gl_r;
  assign correction_sense_en_o = (cor_r != COR_OFF);
  assign bridge_sense_en_o = (brg_r != BRG_OFF);
  assign integrator_limit_o = (cor_r == COR_SOFT);
  assign bridge_period_o = bper_r;
  assign level2_status_o = lvl2_stat_r;
  assign auto_restart_o = (sys_r == SYS_BREAK);
  assign correction_state_o = cor_r;
  assign bridge_state_o = brg_r;

endmodule

// ==== design/plos_pkg.sv ====
// constants and types of the pfc and llc operation sequencer
package plos_pkg;

  // ------------------------------------------------------------
  // clock
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned BO_BLANK_MS = 120;
  localparam int unsigned BO_BLANK_CYC = BO_BLANK_MS * CYC_PER_MS;
  localparam int unsigned AR_BREAK_MS = 1000;
  localparam int unsigned AR_BREAK_CYC = AR_BREAK_MS * CYC_PER_MS;
  localparam int unsigned OLP_TIME_MS = 50;
  localparam int unsigned OLP_TIME_CYC = OLP_TIME_MS * CYC_PER_MS;
  localparam int unsigned MAX_PERIOD_US = 40;
  localparam int unsigned MAX_PERIOD_CYC = MAX_PERIOD_US * 1000 / CLK_NS;
  localparam int unsigned ON_MIN_NS = 200;
  localparam int unsigned ON_MIN_CYC = (ON_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ON_MAX_NS = 20000;
  localparam int unsigned ON_MAX_CYC = ON_MAX_NS / CLK_NS;
  localparam int unsigned INIT_CYC = 4;

  // ------------------------------------------------------------
  // counts and softstart oscillator
  // ------------------------------------------------------------
  localparam logic [3:0] BRIDGE_OVERCURRENT_LEVEL1_LIMIT = 4'h8;
  localparam logic [15:0] TCO_START_PER = 16'h0020;
  localparam logic [15:0] TCO_END_PER = 16'h0080;
  localparam logic [15:0] TCO_STEP_CYC = 16'h0400;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {SYS_INIT, SYS_RUN, SYS_BREAK} plos_sys_t;
  typedef enum logic [1:0] {
    COR_OFF, COR_LOOPCHK, COR_SOFT, COR_NORM
  } plos_cor_t;
  typedef enum logic [1:0] {
    BRG_OFF, BRG_BUSCHK, BRG_SOFT, BRG_NORM
  } plos_brg_t;

endpackage

// ==== design/plos_timer.sv ====
// run-length timer: done while run has held for limit cycles
module plos_timer
  import plos_pkg::*;
#(
  parameter int unsigned W = 26
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);

  if (W < 2) begin : g_chk
    $error("plos_timer: W too small");
  end

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  wire at_limit = (cnt_r >= limit_i);

  assign cnt_nxt = at_limit ? cnt_r : cnt_r + {{(W-1){1'b0}}, 1'b1};
  assign done_o = run_i && at_limit;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !run_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule

// ==== design/plos_corr_gate.sv ====
// correction-stage gate pulse generator
module plos_corr_gate
  import plos_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic zero_cross_i,
  input wire logic overcurrent_i,
  input wire logic block_i,
  input wire logic [W-1:0] on_req_i,
  output logic gate_o
);

  if (W < 10 || W > 31) begin : g_chk
    $error("plos_corr_gate: W out of range");
  end

  localparam logic [W-1:0] MIN_ON = W'(ON_MIN_CYC);
  localparam logic [W-1:0] MAX_ON = W'(ON_MAX_CYC);
  localparam logic [W-1:0] MAX_PER = W'(MAX_PERIOD_CYC - 1);
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

  logic gate_r;
  logic [W-1:0] on_cnt_r;
  logic [W-1:0] per_cnt_r;

  wire [W-1:0] on_len = (on_req_i > MAX_ON) ? MAX_ON : on_req_i;
  wire allow = !block_i && (on_req_i >= MIN_ON);
  wire start = !gate_r && (zero_cross_i || per_cnt_r >= MAX_PER);
  wire fire = enable_i && start && allow;
  wire stop = overcurrent_i || block_i || (on_cnt_r + ONE >= on_len);
  wire [W-1:0] per_nxt = (per_cnt_r >= MAX_PER) ? per_cnt_r
                         : per_cnt_r + ONE;

  assign gate_o = gate_r;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !enable_i) begin
      gate_r <= 1'b0;
      on_cnt_r <= '0;
      per_cnt_r <= '0;
    end else if (fire) begin
      gate_r <= 1'b1;
      on_cnt_r <= '0;
      per_cnt_r <= '0;
    end else begin
      gate_r <= gate_r && !stop;
      on_cnt_r <= on_cnt_r + ONE;
      per_cnt_r <= per_nxt;
    end
  end

endmodule

// ==== tb/plos_sequencer_sva.sv ====
// concurrent checks on the sequencer top-level ports
module plos_sequencer_sva
  import plos_pkg::*;
#(
  parameter int unsigned AR_CYC = AR_BREAK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic bus_open_loop_i,
  input wire logic bus_overvoltage_firmware_i,
  input wire logic bus_overvoltage_hardware_i,
  input wire logic correction_overcurrent_i,
  input wire logic [15:0] on_time_request_i,
  input wire logic line_brownout_i,
  input wire logic bridge_overcurrent_level2_i,
  input wire logic setup_load_o,
  input wire logic correction_gate_o,
  input wire logic bridge_gate_high_o,
  input wire logic bridge_gate_low_o,
  input wire logic correction_sense_en_o,
  input wire logic bridge_sense_en_o,
  input wire logic level2_status_o,
  input wire logic auto_restart_o,
  input wire logic [1:0] correction_state_o,
  input wire logic [1:0] bridge_state_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  int unsigned ar_len_r;
  int unsigned on_len_r;
  // ------------------------------------------------------------
  // run-length helpers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      ar_len_r <= 0;
      on_len_r <= 0;
    end else begin
      ar_len_r <= auto_restart_o ? ar_len_r + 1 : 0;
      on_len_r <= correction_gate_o ? on_len_r + 1 : 0;
    end
  end
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  init_order_a: assert property ($fell(setup_load_o) |->
    correction_state_o == 2'd0 ##1
    (correction_state_o == 2'd1 && bridge_state_o == 2'd1))
    else $error("states did not leave init in order");
  corr_off_quiet_a: assert property (
    correction_state_o == 2'd0 && $past(correction_state_o) == 2'd0
    |-> !correction_gate_o && !correction_sense_en_o)
    else $error("correction stage active while off");
  brg_off_quiet_a: assert property (
    bridge_state_o == 2'd0 && $past(bridge_state_o) == 2'd0
    |-> !bridge_gate_high_o && !bridge_gate_low_o && !bridge_sense_en_o)
    else $error("bridge stage active while off");
  loop_check_a: assert property (correction_state_o == 2'd1 &&
    !bus_open_loop_i && !auto_restart_o && !line_brownout_i &&
    !bridge_overcurrent_level2_i |=> correction_state_o == 2'd2)
    else $error("no softstart after open-loop check");
  ov_block_a: assert property (
    bus_overvoltage_firmware_i || bus_overvoltage_hardware_i
    |-> ##2 !correction_gate_o)
    else $error("gate not blocked on overvoltage");
  oc_cut_a: assert property (
    correction_overcurrent_i && correction_gate_o |=> !correction_gate_o)
    else $error("gate pulse not ended on overcurrent");
  min_on_a: assert property (
    $rose(correction_gate_o) |-> $past(on_time_request_i) >= 16'h0004)
    else $error("gate started with too short request");
  max_on_a: assert property (on_len_r <= 400)
    else $error("gate pulse longer than maximum");
  l2_restart_a: assert property (bridge_overcurrent_level2_i &&
    !auto_restart_o && !setup_load_o |=> auto_restart_o &&
    level2_status_o && bridge_state_o == 2'd0)
    else $error("level-2 event did not start restart");
  break_quiet_a: assert property (
    auto_restart_o && $past(auto_restart_o) |-> !correction_gate_o &&
    !bridge_gate_high_o && !bridge_gate_low_o && correction_state_o == 0)
    else $error("activity during restart break");
  break_len_a: assert property ($fell(auto_restart_o) |->
    ar_len_r >= AR_CYC && ar_len_r <= AR_CYC + 2)
    else $error("restart break has wrong length");
  restart_soft_a: assert property (
    $fell(auto_restart_o) |-> ##[0:3] bridge_state_o == 2'd2)
    else $error("bridge did not restart in softstart");
endmodule

bind plos_sequencer plos_sequencer_sva #(.AR_CYC(AR_CYC)) u_sva (
  .sys_clk_i, .reset_n_i, .bus_open_loop_i, .bus_overvoltage_firmware_i,
  .bus_overvoltage_hardware_i, .correction_overcurrent_i,
  .on_time_request_i, .line_brownout_i, .bridge_overcurrent_level2_i,
  .setup_load_o, .correction_gate_o, .bridge_gate_high_o,
  .bridge_gate_low_o, .correction_sense_en_o, .bridge_sense_en_o,
  .level2_status_o, .auto_restart_o, .correction_state_o, .bridge_state_o);

// ==== tb/plos_power_stage.sv ====
// power stage model: demagnetisation zero crossing and low-side shunt
module plos_power_stage #(
  parameter int unsigned DEMAG = 20
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic gate_i,
  input wire logic low_gate_i,
  input wire logic short_i,
  output logic zero_crossing_o,
  output logic overcurrent_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned demag_r;
  // shunt only carries current while the low-side switch conducts
  assign overcurrent_o = short_i && low_gate_i;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || gate_i) begin
      demag_r <= 0;
      zero_crossing_o <= 1'b0;
    end else begin
      demag_r <= (demag_r <= DEMAG) ? demag_r + 1 : demag_r;
      zero_crossing_o <= (demag_r == DEMAG);
    end
  end
endmodule

// ==== tb/plos_sequencer_tb.sv ====
// self-checking bench of the operation sequencer
module plos_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import plos_pkg::*;
  localparam int AR = 50;
  localparam int BO = 40;
  logic clk, rst_n = 0, ol = 1, near = 0, uv = 0, hb_bus = 0, ovf = 0;
  logic ovh = 0, below = 0, ocp = 0, bo = 0, ccm = 0, fbh = 0, l2 = 0;
  logic l2_clr = 0, short = 0;
  logic [15:0] on_req = 16'h0040, fb_per = 16'hffff, per;
  logic zc, l1, setup, cg, gh, gl, cse, bse, ilim, l2s, ar;
  logic [1:0] cst, bst;
  int mismatches = 0, n_compared = 0, pulses = 0, p;
  plos_sequencer #(.BO_CYC(BO), .AR_CYC(AR), .OLP_CYC(30)) u_dut (
    .sys_clk_i(clk), .reset_n_i(rst_n), .bus_open_loop_i(ol),
    .bus_near_rated_i(near), .bus_undervoltage_i(uv),
    .bridge_startup_bus_i(hb_bus), .bus_overvoltage_firmware_i(ovf),
    .bus_overvoltage_hardware_i(ovh), .bus_below_reference_i(below),
    .correction_overcurrent_i(ocp), .zero_crossing_i(zc),
    .on_time_request_i(on_req), .line_brownout_i(bo), .long_ccm_i(ccm),
    .bridge_overcurrent_level1_i(l1), .bridge_overcurrent_level2_i(l2),
    .bridge_feedback_high_i(fbh), .bridge_feedback_period_i(fb_per),
    .level2_status_clear_i(l2_clr), .setup_load_o(setup),
    .correction_gate_o(cg), .bridge_gate_high_o(gh),
    .bridge_gate_low_o(gl), .correction_sense_en_o(cse),
    .bridge_sense_en_o(bse), .integrator_limit_o(ilim),
    .bridge_period_o(per), .level2_status_o(l2s), .auto_restart_o(ar),
    .correction_state_o(cst), .bridge_state_o(bst));
  plos_power_stage u_stage (.sys_clk_i(clk), .reset_n_i(rst_n),
    .gate_i(cg), .low_gate_i(gl), .short_i(short),
    .zero_crossing_o(zc), .overcurrent_o(l1));
  // ------------------------------------------------------------
  // clock, pulse count, tasks
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge cg) pulses++;
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wait_run(input bit want_ar);
    for (int i = 0; i < 3000; i++) begin
      if (want_ar ? ar === 1'b1 : (cst === 2'd3 && bst === 2'd3)) break;
      cyc(1);
    end
  endtask
  task stop_test;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    cyc(16);
    rst_n = 1'b1;
    cyc(1);
    check({setup, cg, gh, gl, cse, bse}, 16'h0020);
    check(per, 16'h0020);
    cyc(8);
    check({setup, cst, bst}, 16'h0005);
    cyc(20);
    check({cst, cg, bst, gh, gl}, 16'h0024);
    ol = 1'b0;
    cyc(2);
    check({cst, ilim}, 16'h0005);
    cyc(900);
    check(pulses > 0, 1);
    near = 1'b1;
    cyc(2);
    check({cst, ilim}, 16'h0006);
    ocp = 1'b1;
    cyc(3);
    ocp = 1'b0;
    check(cst, 2'd3);
    for (int k = 0; k < 2; k++) begin
      {ovf, ovh} = k ? 2'b01 : 2'b10;
      cyc(2);
      p = pulses;
      cyc(1000);
      {ovf, ovh} = 2'b00;
      cyc(5);
      check({pulses == p, cst, bst}, 16'h001d);
      below = 1'b1;
      cyc(900);
      check(pulses > p, 1);
      below = 1'b0;
    end
    on_req = 16'h0002;
    cyc(10);
    p = pulses;
    cyc(1000);
    check(pulses == p, 1);
    on_req = 16'h0300;
    hb_bus = 1'b1;
    cyc(2);
    check(bst, 2'd2);
    cyc(16'h0430);
    check(per, 16'h0021);
    fb_per = 16'h0010;
    cyc(2);
    check(bst, 2'd3);
    cyc(80);
    check(per, 16'h0010);
    uv = 1'b1;
    hb_bus = 1'b0;
    cyc(2);
    check(bst, 2'd1);
    uv = 1'b0;
    hb_bus = 1'b1;
    bo = 1'b1;
    cyc(BO - 10);
    check(cst, 2'd3);
    cyc(15);
    check({cst, bst}, 16'h0003);
    bo = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wait_run(0);
      check({cst, bst}, 16'h000f);
      case (k)
        0: l2 = 1'b1;
        1: ccm = 1'b1;
        2: fbh = 1'b1;
        default: short = 1'b1;
      endcase
      cyc(1);
      l2 = 1'b0;
      wait_run(1);
      {ccm, fbh, short} = 3'b000;
      check(ar, 1);
      cyc(2);
      check({cst, bst, cg, gh, gl}, 16'h0000);
      if (k == 0) begin
        check(l2s, 1);
        l2_clr = 1'b1;
        cyc(1);
        l2_clr = 1'b0;
        cyc(1);
        check(l2s, 0);
      end
      cyc(AR + 4);
      check({ar, bst != 2'd0}, 16'h0001);
    end
    stop_test;
  end
endmodule
